// ===== design/rx_char_fifo.sv
// Receive buffer FIFO with valid/ready on both sides
`timescale 1ns/10ps
module rx_char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] wr_ptr; // Next slot to fill
    logic [AW-1:0] rd_ptr; // Oldest slot
    logic [AW:0] count;    // Words held
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t next_q;
  logic [WIDTH-1:0] mem [DEPTH]; // Character storage
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = (q.count != (AW+1)'(DEPTH));
  assign out_valid = (q.count != '0);
  assign out_data = mem[q.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_q.rd_ptr = q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_q.count = q.count + 1'b1;
    end else if (pop && !push) begin
      next_q.count = q.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Storage write; no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[q.wr_ptr] <= in_data;
    end
  end
endmodule

// ===== design/uart_pkg.sv
// Types shared by the serial transmit and receive path
package uart_pkg;

  // ----------------------------------------------------------------
  // Transmitter states, Gray coded along the frame
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_PARITY = 3'h2,
    TX_STOP = 3'h6
  } tx_state_t;

  // ----------------------------------------------------------------
  // Receiver states, Gray coded along the frame
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP = 3'h6,
    RX_HOLD = 3'h7
  } rx_state_t;

endpackage

// ===== design/uart_regs.svh
// Constants for the serial transmit and receive path
`ifndef UART_REGS_SVH
`define UART_REGS_SVH

// ----------------------------------------------------------------
// Field widths and encodings
// ----------------------------------------------------------------
`define BAUD_DIV_WIDTH 12
`define CHAR_SIZE_5 3'h0
`define CHAR_SIZE_6 3'h1
`define CHAR_SIZE_7 3'h2
`define CHAR_SIZE_8 3'h3
`define CHAR_SIZE_9 3'h7

// ----------------------------------------------------------------
// Transmit clock division and receive half-bit delay per mode
// ----------------------------------------------------------------
`define TX_DIV_NORMAL 4'hf
`define TX_DIV_DOUBLE 4'h7
`define RX_HALF_NORMAL 4'h7
`define RX_HALF_DOUBLE 4'h3

// ----------------------------------------------------------------
// Reset values and buffer shape
// ----------------------------------------------------------------
`define BAUD_CNT_RESET 12'h000
`define CHAR_RESET 9'h000
`define RX_FIFO_DEPTH 32
`define CHAR_WIDTH 9

`endif

// ===== design/uart_transmit_receive_path.sv
// Serial transmitter and receive front end of a UART
//
// Overview of operation
// - Transmit enable takes over the output pin.
// - Synchronous mode transmits on external transfer clock.
// - Data register write loads transmit buffer.
// - Buffer moves to shifter when idle/after stop.
// - Shifter sends full frame at selected rate.
// - Unused upper bits ignored on transmit.
// - Ninth bit taken from control bit.
// - Data-empty flag shows transmit buffer empty.
// - Data register write clears data-empty flag.
// - Data-empty interrupt requested while flag set.
// - Transmit-done set after frame, buffer empty.
// - Transmit-done cleared by service or write-one.
// - Transmit-done interrupt requested when flag sets.
// - Parity bit inserted after data when enabled.
// - Disable waits until shifter and buffer empty.
// - Receive enable takes input; sync uses external clock.
// - Reception starts on valid start bit.
// - Second stop bit ignored by receiver.
// - First stop bit moves frame to buffer.
// - Unused upper received bits read zero.
// - Start low, LSB first, parity, stop high.
// - Parity is data XOR, inverted when odd.
// - Baud down-counter; transmit divides 16, or 8 at double speed.
// - Receive-done flag shows unread buffered data.
`timescale 1ns/10ps
`include "uart_regs.svh"
module uart_transmit_receive_path (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic transmit_enable_bit,
  input wire logic receive_enable_bit,
  input wire logic sync_mode,
  input wire logic clock_polarity,
  input wire logic double_speed_bit,
  input wire logic [2:0] char_size_field,
  input wire logic parity_enable_bit,
  input wire logic parity_odd_select,
  input wire logic stop_bits_select,
  input wire logic transmit_ninth_bit,
  input wire logic [`BAUD_DIV_WIDTH-1:0] baud_divisor,
  input wire logic baud_divisor_low_wr,
  input wire logic data_empty_irq_enable,
  input wire logic transmit_done_irq_enable,
  input wire logic transmit_done_clear_wr,
  input wire logic transmit_done_irq_ack,
  input wire logic serial_data_wr,
  input wire logic [7:0] serial_data_wdata,
  input wire logic serial_data_rd,
  output logic [7:0] serial_data_rdata,
  output logic receive_ninth_bit,
  output logic data_empty_flag,
  output logic transmit_done_flag,
  output logic receive_done_flag,
  output logic data_empty_irq,
  output logic transmit_done_irq,
  output logic serial_out_pin,
  output logic serial_out_oe,
  input wire logic serial_in_pin,
  input wire logic transfer_clock_pin,
  output logic rx_overrun_stall
);
  import uart_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Data bits per character, minus one
  function automatic logic [3:0] last_bit(input logic [2:0] cs);
    case (cs)
      `CHAR_SIZE_5: last_bit = 4'h4;
      `CHAR_SIZE_6: last_bit = 4'h5;
      `CHAR_SIZE_7: last_bit = 4'h6;
      `CHAR_SIZE_9: last_bit = 4'h8;
      default: last_bit = 4'h7;
    endcase
  endfunction

  // Zero the bits above the character size
  function automatic logic [8:0] mask_char(input logic [8:0] d, input logic [2:0] cs);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < 9; i++) begin
      m[i] = (4'(i) <= last_bit(cs));
    end
    mask_char = d & m;
  endfunction

  // ----------------------------------------------------------------
  // State of the whole block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rx_sync;   // Receive pin synchroniser, bit 0 first
    logic rx_level;        // Filtered receive line
    logic [2:0] xck_sync;  // Transfer clock synchroniser
    logic xck_level;       // Filtered transfer clock
    logic [`BAUD_DIV_WIDTH-1:0] baud_cnt; // Baud down-counter
    logic [3:0] tx_pre;    // Transmit prescaler
    tx_state_t tx_state;
    logic [3:0] tx_bit;    // Data bit index
    logic [8:0] tx_shift;  // Transmit shift register
    logic tx_par;          // Parity of the frame in flight
    logic tx_stop2;        // Second stop bit in progress
    logic tx_line;         // Level on the output pin
    logic tx_owned;        // Transmitter holds the pin
    logic tbuf_full;       // Transmit buffer occupied
    logic [8:0] tbuf;      // Transmit buffer
    logic tx_done;         // Transmit-done flag
    rx_state_t rx_state;
    logic [3:0] rx_phase;  // Baud ticks to next sample
    logic [3:0] rx_bit;    // Data bit index
    logic [8:0] rx_shift;  // Receive shift register
  } core_t;

  core_t q;
  core_t next_q;
  logic baud_tick;   // Baud generator output
  logic xck_new;     // Filtered transfer clock, next value
  logic rx_new;      // Filtered receive line, next value
  logic xck_rise;
  logic xck_fall;
  logic tx_tick;     // One transmit bit period elapsed
  logic rx_samp;     // Receive sample point
  logic do_load;     // Buffer moves into shifter
  logic done_set;    // Transmit-done set event
  logic fifo_valid;
  logic fifo_ready;
  logic [8:0] fifo_out;
  logic [3:0] div;

  // ----------------------------------------------------------------
  // Pin filtering and clock events
  // ----------------------------------------------------------------
  // A change counts once the second and third stages agree
  always_comb begin
    rx_new = (q.rx_sync[1] == q.rx_sync[2]) ? q.rx_sync[2] : q.rx_level;
    xck_new = (q.xck_sync[1] == q.xck_sync[2]) ? q.xck_sync[2] : q.xck_level;
    xck_rise = xck_new && !q.xck_level;
    xck_fall = !xck_new && q.xck_level;
    baud_tick = (q.baud_cnt == '0);
    div = double_speed_bit ? `TX_DIV_DOUBLE : `TX_DIV_NORMAL;
    // External clock edges replace the baud rate when synchronous
    tx_tick = sync_mode ? (clock_polarity ? xck_fall : xck_rise)
                        : (baud_tick && q.tx_pre == div);
    rx_samp = sync_mode ? (clock_polarity ? xck_rise : xck_fall)
                        : (baud_tick && q.rx_phase == 4'h0);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    do_load = 1'b0;
    done_set = 1'b0;
    next_q.rx_sync = {q.rx_sync[1:0], serial_in_pin};
    next_q.xck_sync = {q.xck_sync[1:0], transfer_clock_pin};
    next_q.rx_level = rx_new;
    next_q.xck_level = xck_new;

    // Baud generator reloads at zero or on a low-byte write
    if (baud_divisor_low_wr || baud_tick) begin
      next_q.baud_cnt = baud_divisor;
    end else begin
      next_q.baud_cnt = q.baud_cnt - 1'b1;
    end
    if (baud_tick) begin
      next_q.tx_pre = (q.tx_pre == div) ? 4'h0 : q.tx_pre + 1'b1;
    end

    // Pin ownership is held until nothing is left to send
    next_q.tx_owned = transmit_enable_bit
                      || (q.tx_owned && (q.tx_state != TX_IDLE || q.tbuf_full));

    // Frame sequencer, one step per bit period
    if (tx_tick && q.tx_owned) begin
      case (q.tx_state)
        TX_IDLE: begin
          do_load = q.tbuf_full;
        end
        TX_START: begin
          next_q.tx_line = q.tx_shift[0];
          next_q.tx_shift = q.tx_shift >> 1;
          next_q.tx_bit = 4'h0;
          next_q.tx_state = TX_DATA;
        end
        TX_DATA: begin
          if (q.tx_bit == last_bit(char_size_field)) begin
            if (parity_enable_bit) begin
              next_q.tx_line = q.tx_par;
              next_q.tx_state = TX_PARITY;
            end else begin
              next_q.tx_line = 1'b1;
              next_q.tx_stop2 = 1'b0;
              next_q.tx_state = TX_STOP;
            end
          end else begin
            next_q.tx_line = q.tx_shift[0];
            next_q.tx_shift = q.tx_shift >> 1;
            next_q.tx_bit = q.tx_bit + 1'b1;
          end
        end
        TX_PARITY: begin
          next_q.tx_line = 1'b1;
          next_q.tx_stop2 = 1'b0;
          next_q.tx_state = TX_STOP;
        end
        TX_STOP: begin
          if (stop_bits_select && !q.tx_stop2) begin
            next_q.tx_stop2 = 1'b1;
          end else if (q.tbuf_full) begin
            do_load = 1'b1;
          end else begin
            next_q.tx_state = TX_IDLE;
            done_set = 1'b1;
          end
        end
        default: begin
          next_q.tx_state = TX_IDLE;
        end
      endcase
    end

    // Buffer into shifter; start bit goes out at once
    if (do_load) begin
      next_q.tx_shift = q.tbuf;
      next_q.tx_par = (^q.tbuf) ^ parity_odd_select;
      next_q.tx_line = 1'b0;
      next_q.tx_state = TX_START;
      next_q.tbuf_full = 1'b0;
    end

    // Host write fills the single buffer after any move
    if (serial_data_wr) begin
      next_q.tbuf = mask_char({transmit_ninth_bit, serial_data_wdata}, char_size_field);
      next_q.tbuf_full = 1'b1;
    end

    // Flag clear by service or write-one; a new set wins
    if (transmit_done_irq_ack || transmit_done_clear_wr) begin
      next_q.tx_done = 1'b0;
    end
    if (done_set) begin
      next_q.tx_done = 1'b1;
    end

    // Receive sample phase in asynchronous mode
    if (baud_tick && !sync_mode && q.rx_state != RX_IDLE) begin
      next_q.rx_phase = (q.rx_phase == 4'h0) ? div : q.rx_phase - 1'b1;
    end

    // Receiver sequencer
    if (!receive_enable_bit) begin
      next_q.rx_state = RX_IDLE;
    end else begin
      case (q.rx_state)
        RX_IDLE: begin
          if (!sync_mode && q.rx_level && !rx_new) begin
            next_q.rx_phase = double_speed_bit ? `RX_HALF_DOUBLE : `RX_HALF_NORMAL;
            next_q.rx_state = RX_START;
          end else if (sync_mode && rx_samp && !q.rx_level) begin
            next_q.rx_bit = 4'h0;
            next_q.rx_state = RX_DATA;
          end
        end
        RX_START: begin
          // A start bit that is high again mid-bit was noise
          if (rx_samp) begin
            next_q.rx_bit = 4'h0;
            next_q.rx_state = q.rx_level ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_samp) begin
            next_q.rx_shift[q.rx_bit] = q.rx_level;
            next_q.rx_bit = q.rx_bit + 1'b1;
            if (q.rx_bit == last_bit(char_size_field)) begin
              next_q.rx_state = parity_enable_bit ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_samp) begin
            next_q.rx_state = RX_STOP;
          end
        end
        RX_STOP: begin
          // Frame ends at the first stop bit; any second is idle line
          if (rx_samp) begin
            next_q.rx_state = fifo_ready ? RX_IDLE : RX_HOLD;
          end
        end
        RX_HOLD: begin
          // Full buffer stalls the receiver; new frames are lost
          if (fifo_ready) begin
            next_q.rx_state = RX_IDLE;
          end
        end
        default: begin
          next_q.rx_state = RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.rx_sync <= 3'h7;
      q.rx_level <= 1'b1;
      q.baud_cnt <= `BAUD_CNT_RESET;
      q.tx_line <= 1'b1;
      q.tbuf <= `CHAR_RESET;
      q.tx_state <= TX_IDLE;
      q.rx_state <= RX_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  rx_char_fifo #(
    .WIDTH(`CHAR_WIDTH),
    .DEPTH(`RX_FIFO_DEPTH)
  ) u_rx_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid((q.rx_state == RX_STOP && rx_samp) || q.rx_state == RX_HOLD),
    .in_ready(fifo_ready),
    .in_data(mask_char(q.rx_shift, char_size_field)),
    .out_valid(fifo_valid),
    .out_ready(serial_data_rd),
    .out_data(fifo_out)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_data_rdata = fifo_out[7:0];
  assign receive_ninth_bit = fifo_out[8];
  assign receive_done_flag = fifo_valid;
  assign data_empty_flag = !q.tbuf_full;
  assign transmit_done_flag = q.tx_done;
  assign data_empty_irq = data_empty_irq_enable && !q.tbuf_full;
  assign transmit_done_irq = transmit_done_irq_enable && q.tx_done;
  assign serial_out_pin = q.tx_line;
  assign serial_out_oe = q.tx_owned;
  assign rx_overrun_stall = (q.rx_state == RX_HOLD);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_last_stop;
    q.tx_state == TX_STOP && tx_tick && !q.tbuf_full && (!stop_bits_select || q.tx_stop2);
  endsequence

  property p_enable_owns;
    @(posedge clk_sys) disable iff (rst) transmit_enable_bit |=> serial_out_oe;
  endproperty
  a_enable_owns: assert property (p_enable_owns) else $error("pin not taken on enable");

  property p_write_clears_empty;
    @(posedge clk_sys) disable iff (rst) serial_data_wr |=> !data_empty_flag;
  endproperty
  a_write_clears_empty: assert property (p_write_clears_empty) else $error("empty flag stayed set");

  property p_empty_on_move;
    @(posedge clk_sys) disable iff (rst) $rose(data_empty_flag) |-> $past(tx_tick) && serial_out_pin == 1'b0;
  endproperty
  a_empty_on_move: assert property (p_empty_on_move) else $error("buffer emptied without a move");

  property p_empty_irq;
    @(posedge clk_sys) disable iff (rst) data_empty_flag && data_empty_irq_enable |-> data_empty_irq;
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("empty interrupt missing");

  property p_done_after_frame;
    @(posedge clk_sys) disable iff (rst) s_last_stop |=> transmit_done_flag && q.tx_state == TX_IDLE;
  endproperty
  a_done_after_frame: assert property (p_done_after_frame) else $error("done flag not set");

  property p_done_cleared;
    @(posedge clk_sys) disable iff (rst) transmit_done_irq_ack && !done_set |=> !transmit_done_flag;
  endproperty
  a_done_cleared: assert property (p_done_cleared) else $error("done flag not cleared");

  property p_done_irq;
    @(posedge clk_sys) disable iff (rst)
      $rose(transmit_done_flag) && transmit_done_irq_enable |-> transmit_done_irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done interrupt missing");

  property p_disable_waits;
    @(posedge clk_sys) disable iff (rst) q.tx_state != TX_IDLE |=> serial_out_oe;
  endproperty
  a_disable_waits: assert property (p_disable_waits) else $error("pin released mid frame");

  property p_start_low_stop_high;
    @(posedge clk_sys) disable iff (rst)
      (q.tx_state == TX_START |-> !serial_out_pin) and (q.tx_state == TX_STOP |-> serial_out_pin);
  endproperty
  a_start_low_stop_high: assert property (p_start_low_stop_high) else $error("bad frame level");

  property p_push_sets_ready;
    @(posedge clk_sys) disable iff (rst)
      q.rx_state == RX_STOP && rx_samp && fifo_ready |=> receive_done_flag && q.rx_state != RX_STOP;
  endproperty
  a_push_sets_ready: assert property (p_push_sets_ready) else $error("frame not buffered");
endmodule

// ===== tb/test_uart_transmit_receive_path.sv
// Self-checking bench for the serial transmit and receive path
`timescale 1ns/10ps
`include "uart_regs.svh"
module test_uart_transmit_receive_path;
  logic clk_sys, rst, transmit_enable_bit, receive_enable_bit, sync_mode, clock_polarity, double_speed_bit;
  logic [2:0] char_size_field;
  logic parity_enable_bit, parity_odd_select, stop_bits_select, transmit_ninth_bit, baud_divisor_low_wr;
  logic [`BAUD_DIV_WIDTH-1:0] baud_divisor;
  logic data_empty_irq_enable, transmit_done_irq_enable, transmit_done_clear_wr, transmit_done_irq_ack;
  logic serial_data_wr, serial_data_rd, receive_ninth_bit, data_empty_flag, transmit_done_flag;
  logic [7:0] serial_data_wdata, serial_data_rdata;
  logic receive_done_flag, data_empty_irq, transmit_done_irq, serial_out_pin, serial_out_oe;
  logic serial_in_pin, transfer_clock_pin, rx_overrun_stall, tx_line;
  logic [15:0] bit_ns;
  logic [3:0] nbits;
  logic [8:0] ws[3];
  logic [2:0] codes[5] = '{`CHAR_SIZE_5, `CHAR_SIZE_6, `CHAR_SIZE_7, `CHAR_SIZE_8, `CHAR_SIZE_9};
  int error_cnt, tests_run, seed;

  assign tx_line = serial_out_oe ? serial_out_pin : 1'b1; // Pull-up while released
  uart_transmit_receive_path DUT (.*);
  uart_far_end far (.line_in(tx_line), .line_out(serial_in_pin), .bit_ns(bit_ns), .nbits(nbits),
    .par_en(parity_enable_bit));

  // ------------------------------------------------------------
  // Expectation helpers
  // ------------------------------------------------------------
  function automatic logic [8:0] masked(input logic [8:0] w);
    return w & (9'h1ff >> (9 - nbits)); // Unused upper bits dropped
  endfunction
  function automatic logic par_of(input logic [8:0] w);
    return parity_enable_bit & (^masked(w) ^ parity_odd_select);
  endfunction
  function automatic logic flag_of(input int s);
    return s == 0 ? data_empty_flag : s == 1 ? transmit_done_flag : receive_done_flag;
  endfunction

  // ------------------------------------------------------------
  // Compare, wait and verdict tasks
  // ------------------------------------------------------------
  task automatic cmp(input string name, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_flag(input int s);
    int n;
    n = 0;
    while (flag_of(s) !== 1'b1 && n < 20000) begin
      tick();
      n++;
    end
    if (n == 20000) begin // Hang cut short
      error_cnt++;
      $display("mismatch flag %0d expected 1 seen timeout", s);
      print_verdict();
    end
  endtask
  // Random frame format, shared by both directions
  task automatic pick_format(input int c);
    char_size_field = codes[c];
    nbits = (c == 4) ? 4'd9 : 4'(c + 5);
    {double_speed_bit, parity_enable_bit, parity_odd_select, stop_bits_select} = 4'($random(seed));
    bit_ns = double_speed_bit ? 16'd160 : 16'd320; // Eight or sixteen ticks of divisor 1
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 57174;
    error_cnt = 0;
    tests_run = 0;
    {transmit_enable_bit, receive_enable_bit, sync_mode, clock_polarity, transfer_clock_pin} = '0;
    {transmit_ninth_bit, baud_divisor_low_wr, transmit_done_clear_wr, transmit_done_irq_ack} = '0;
    {serial_data_wr, serial_data_rd, serial_data_wdata} = '0;
    {data_empty_irq_enable, transmit_done_irq_enable} = 2'b11;
    baud_divisor = 12'h001;
    pick_format(3);
    rst = 1'b1;
    repeat (12) tick();
    rst = 1'b0;
    baud_divisor_low_wr = 1'b1;
    tick();
    baud_divisor_low_wr = 1'b0;
    transmit_enable_bit = 1'b1;
    receive_enable_bit = 1'b1;
    // Transmit bursts of three back-to-back words per size code
    for (int b = 0; b < 6; b++) begin
      pick_format(b % 5);
      {data_empty_irq_enable, transmit_done_irq_enable} = 2'($random(seed));
      for (int i = 0; i < 3; i++) begin
        ws[i] = 9'($random(seed));
        wait_flag(0);
        cmp("data_empty_irq", {10'h0, data_empty_irq_enable}, {10'h0, data_empty_irq});
        serial_data_wr = 1'b1;
        serial_data_wdata = ws[i][7:0];
        transmit_ninth_bit = ws[i][8];
        tick();
        serial_data_wr = 1'b0;
        transmit_ninth_bit = ~ws[i][8];
        if (b == 5 && i == 2) transmit_enable_bit = 1'b0; // Disable with a frame pending
        tick();
        cmp("serial_out_oe", 11'h1, {10'h0, serial_out_oe});
        if (i > 0) begin // Shifter busy, so the word waits in the buffer
          cmp("data_empty_flag", 11'h0, {10'h0, data_empty_flag});
          cmp("transmit_done_flag", 11'h0, {10'h0, transmit_done_flag});
        end
      end
      wait_flag(1);
      cmp("transmit_done_irq", {10'h0, transmit_done_irq_enable}, {10'h0, transmit_done_irq});
      for (int i = 0; i < 3; i++) begin
        cmp("decoded frame", {1'b1, par_of(ws[i]), masked(ws[i])}, far.rx_q.pop_front());
      end
      // Clear the done flag by write-one on odd bursts, by interrupt service on even ones
      if (b[0]) transmit_done_clear_wr = 1'b1;
      else transmit_done_irq_ack = 1'b1;
      tick();
      {transmit_done_clear_wr, transmit_done_irq_ack} = 2'b00;
      tick();
      cmp("transmit_done_flag", 11'h0, {10'h0, transmit_done_flag});
    end
    repeat (4) tick();
    cmp("serial_out_oe", 11'h0, {10'h0, serial_out_oe});
    // Receive two frames back-to-back per size code, the first with two stop bits, the second with one
    for (int c = 0; c < 5; c++) begin
      pick_format(c);
      ws[0] = 9'($random(seed));
      ws[1] = 9'($random(seed));
      far.send(ws[0], nbits, parity_enable_bit, par_of(ws[0]), 2);
      far.send(ws[1], nbits, parity_enable_bit, par_of(ws[1]), 1);
      for (int i = 0; i < 2; i++) begin
        wait_flag(2);
        cmp("received word", {2'b0, masked(ws[i])}, {2'b0, receive_ninth_bit, serial_data_rdata});
        serial_data_rd = 1'b1;
        tick();
        serial_data_rd = 1'b0;
        tick();
      end
      tick();
      cmp("receive_done_flag", 11'h0, {10'h0, receive_done_flag});
      cmp("rx_overrun_stall", 11'h0, {10'h0, rx_overrun_stall});
    end
    print_verdict();
  end
endmodule

// ===== tb/uart_far_end.sv
// Far-end serial transceiver model: frame decoder and frame sender
`timescale 1ns/10ps
module uart_far_end (
  input wire logic line_in,
  output logic line_out,
  input wire logic [15:0] bit_ns,
  input wire logic [3:0] nbits,
  input wire logic par_en
);
  logic [10:0] rx_q[$]; // Decoded frames as {stop, parity, data}

  initial line_out = 1'b1; // Idle line high

  // ------------------------------------------------------------
  // Decoder, sampling each bit in its middle
  // ------------------------------------------------------------
  always @(negedge line_in) begin : dec
    logic [8:0] w;
    logic p;
    w = '0;
    p = 1'b0;
    #(bit_ns / 2);
    if (line_in == 1'b0) begin // Start bit low, data LSB first
      for (int i = 0; i < nbits; i++) begin
        #(bit_ns);
        w[i] = line_in;
      end
      if (par_en) begin // Parity after the data
        #(bit_ns);
        p = line_in;
      end
      #(bit_ns);
      rx_q.push_back({line_in, p, w});
    end
  end

  // ------------------------------------------------------------
  // Sender; the line stays driven high after the stop bits
  // ------------------------------------------------------------
  task automatic send(input logic [8:0] w, input int n, input logic pe, input logic p, input int stops);
    line_out = 1'b0; // Start bit
    #(bit_ns);
    for (int i = 0; i < n; i++) begin
      line_out = w[i];
      #(bit_ns);
    end
    if (pe) begin
      line_out = p;
      #(bit_ns);
    end
    line_out = 1'b1; // Stop bits high
    #(bit_ns * stops);
  endtask
endmodule
